// >>> src/pllc_pkg.sv
package pllc_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] CTRL_OFS = 8'h00; // pll control
   localparam logic [7:0] BW_OFS = 8'h04; // bandwidth control
   localparam logic [7:0] MUL_OFS = 8'h08; // feedback multiplier
   localparam logic [7:0] VRS_OFS = 8'h0C; // vco range select
   localparam logic [7:0] RDS_OFS = 8'h10; // reference divider select
   localparam logic [7:0] BRK_OFS = 8'h14; // break flag control
   // field positions in the control register
   localparam int CTRL_IE = 7; // irq enable
   localparam int CTRL_IF = 6; // irq flag, read only
   localparam int CTRL_ON = 5; // pll enable
   localparam int CTRL_BCS = 4; // base clock select
   localparam int CTRL_PRE = 2; // prescaler, two bits
   localparam int CTRL_VPR = 0; // power-of-two range, two bits
   // field positions elsewhere
   localparam int BW_AUTO = 7; // automatic bandwidth
   localparam int BW_LOCK = 6; // lock indicator, read only
   localparam int BW_ACQ = 5; // acquisition / tracking
   localparam int BRK_BREAK_CLEAR_ENABLE = 7; // break clear enable
   // values after reset
   localparam logic [7:0] VRS_RST = 8'h40;
   localparam logic [3:0] RDS_RST = 4'h1;
   localparam logic [11:0] MUL_RST = 12'h040;
   localparam logic ON_RST = 1'b1;
   // source edges waited on each side of a clock switch
   localparam int SWITCH_EDGES = 3;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : pllc_pkg

// >>> src/pllc_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for a level from another domain
module pllc_sync #(
   parameter int STAGES = 2 // flip-flops in the chain
) (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic din, // asynchronous level
   output logic dout // synchronised level
);
   logic [STAGES-1:0] chain_q; // only the last stage is read

   initial begin
      if (STAGES < 2) begin
         $error("pllc_sync needs at least two stages");
      end
   end

   // shift chain; only the next stage looks at the first stage
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chain_q <= '0;
      end else begin
         chain_q <= {chain_q[STAGES-2:0], din};
      end
   end

   assign dout = chain_q[STAGES-1];
endmodule : pllc_sync

// >>> src/pllc_clk_switch.sv
`timescale 1ns/1ps
// glitch-free base clock selector: divide-by-two of the chosen source
module pllc_clk_switch (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic osc_lvl, // synchronised oscillator clock level
   input wire logic vco_lvl, // synchronised divided vco clock level
   input wire logic sel_req, // requested source, 1 = vco
   output logic base_clock_out, // divided-by-two selected clock
   output logic sel_active // source now driving the output
);
   typedef enum logic [1:0] {
      SW_RUN = 2'b00, // toggling on the active source
      SW_OLD = 2'b01, // stasis, counting old source edges
      SW_NEW = 2'b10 // stasis, counting new source edges
   } pllc_sw_e;

   pllc_sw_e st_q; // switch state
   logic [1:0] cnt_q; // edges seen in this phase
   logic osc_d1_q; // previous oscillator level
   logic vco_d1_q; // previous vco level
   logic osc_rise; // oscillator rising edge
   logic vco_rise; // vco rising edge
   logic act_rise; // rising edge of active source
   logic new_rise; // rising edge of requested source

   assign osc_rise = osc_lvl & ~osc_d1_q;
   assign vco_rise = vco_lvl & ~vco_d1_q;
   assign act_rise = sel_active ? vco_rise : osc_rise;
   assign new_rise = sel_req ? vco_rise : osc_rise;

   // edge history
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_d1_q <= 1'b0;
         vco_d1_q <= 1'b0;
      end else begin
         osc_d1_q <= osc_lvl;
         vco_d1_q <= vco_lvl;
      end
   end

   // hold the output still until both sources have been seen settle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= SW_RUN;
         cnt_q <= 2'b00;
         sel_active <= 1'b0;
      end else begin
         case (st_q)
            SW_RUN: begin
               if (sel_req != sel_active) begin
                  st_q <= SW_OLD;
                  cnt_q <= 2'b00;
               end
            end
            SW_OLD: begin
               // waits for SWITCH_EDGES edges of the old source; a stopped old source hangs the switch
               if (act_rise) begin
                  if (cnt_q == 2'(pllc_pkg::SWITCH_EDGES - 1)) begin
                     st_q <= SW_NEW;
                     cnt_q <= 2'b00;
                  end else begin
                     cnt_q <= cnt_q + 2'b01;
                  end
               end
            end
            SW_NEW: begin
               if (new_rise) begin
                  if (cnt_q == 2'(pllc_pkg::SWITCH_EDGES - 1)) begin
                     st_q <= SW_RUN;
                     sel_active <= sel_req;
                     cnt_q <= 2'b00;
                  end else begin
                     cnt_q <= cnt_q + 2'b01;
                  end
               end
            end
            default: begin
               st_q <= SW_RUN;
            end
         endcase
      end
   end

   // output toggles only while running, so no shortened pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         base_clock_out <= 1'b0;
      end else if (st_q == SW_RUN && act_rise) begin
         base_clock_out <= ~base_clock_out;
      end
   end
endmodule : pllc_clk_switch

// >>> src/pllc_top.sv
// The placing of the registers and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
module pllc_top (
   input wire logic aclk, // system clock, 20 MHz
   input wire logic aresetn, // synchronous reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic pll_locked_in, // lock detector level, async
   input wire logic osc_clock, // oscillator clock level, async
   input wire logic divided_vco_clock, // divided vco clock level, async
   input wire logic stop_mode, // stop mode active
   input wire logic debug_break, // debug break state active
   output logic pll_irq, // interrupt request to processor
   output logic pll_run, // analog loop and vco enable
   output logic [7:0] vco_range, // range multiplier to vco
   output logic [3:0] ref_div, // effective reference divider
   output logic [11:0] feedback_mul, // effective feedback multiplier
   output logic [1:0] prescale, // prescaler code
   output logic [1:0] vco_power, // power-of-two range code
   output logic auto_bw, // automatic bandwidth mode
   output logic acq_track, // acquisition/tracking control, manual value or lock level in auto mode
   output logic base_clock_out, // base clock to system unit
   output logic base_vco_active // vco path now drives base clock
);
   // byte merge for one register lane group
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // a value of zero behaves as one
   function automatic logic [11:0] zero_as_one(input logic [11:0] v);
      return (v == 12'h000) ? 12'h001 : v;
   endfunction : zero_as_one

   // software state
   logic pll_irq_enable_q; // interrupt enable
   logic pll_irq_flag_q; // lock change flag
   logic pll_enable_q; // pll on
   logic base_clock_select_q; // vco path requested
   logic [1:0] pre_q; // prescaler bits
   logic [1:0] vpr_q; // power range bits
   logic auto_q; // automatic bandwidth
   logic acq_q; // manual acquisition value
   logic [11:0] mul_q; // feedback_multiplier_field
   logic [7:0] vco_range_field_q; // vco_range_field
   logic [3:0] ref_divider_field_q; // ref_divider_field
   logic break_clear_enable_q; // break_clear_enable
   // bus state
   logic aw_held_q; // write address captured
   logic w_held_q; // write data captured
   logic [7:0] awaddr_q; // captured write address
   logic [31:0] wdata_q; // captured write data
   logic [3:0] wstrb_q; // captured strobes
   // lock tracking
   logic lock_s; // synchronised lock
   logic lock_d1_q; // previous lock
   logic osc_s; // synchronised oscillator
   logic vco_s; // synchronised vco clock
   logic lock_chg; // lock toggled
   // decode helpers
   logic wr_go; // both halves held, response slot free
   logic rd_go; // read address taken this cycle
   logic wr_ctrl; // write to control register
   logic rd_ctrl; // read of control register
   logic [31:0] ctrl_w; // merged control write value
   logic [31:0] rd_val; // read mux
   logic rd_hit; // read address mapped
   logic wr_hit; // write address mapped
   logic range_zero; // vco range all clear
   logic flag_clr; // flag cleared by this read
   logic vco_gated; // vco level with stop gating

   pllc_sync u_sync_lock (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(pll_locked_in),
      .dout(lock_s)
   );

   pllc_sync u_sync_osc (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(osc_clock),
      .dout(osc_s)
   );

   pllc_sync u_sync_vco (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(divided_vco_clock),
      .dout(vco_s)
   );

   assign wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
   assign rd_go = s_axi_arvalid & s_axi_arready;
   assign wr_hit = (awaddr_q == pllc_pkg::CTRL_OFS) || (awaddr_q == pllc_pkg::BW_OFS) ||
                   (awaddr_q == pllc_pkg::MUL_OFS) || (awaddr_q == pllc_pkg::VRS_OFS) ||
                   (awaddr_q == pllc_pkg::RDS_OFS) || (awaddr_q == pllc_pkg::BRK_OFS);
   assign wr_ctrl = wr_go & (awaddr_q == pllc_pkg::CTRL_OFS);
   assign rd_ctrl = rd_go & (s_axi_araddr == pllc_pkg::CTRL_OFS);
   assign ctrl_w = merge(32'h0000_0000, wdata_q, wstrb_q);
   assign range_zero = (vco_range_field_q == 8'h00);
   assign lock_chg = lock_s ^ lock_d1_q;
   // read clears unless break protects the flag
   assign flag_clr = rd_ctrl & (~debug_break | break_clear_enable_q);
   // no vco clock reaches the selector in stop
   assign vco_gated = vco_s & ~stop_mode;

   // write address and data are taken independently, held until answered
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end else if (wr_go) begin
            aw_held_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = ~aw_held_q;
   assign s_axi_wready = ~w_held_q;

   // write response, one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= pllc_pkg::RESP_OKAY;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_hit ? pllc_pkg::RESP_OKAY : pllc_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control register; protected fields keep their value on blocked writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pll_irq_enable_q <= 1'b0;
         pll_enable_q <= pllc_pkg::ON_RST;
         base_clock_select_q <= 1'b0;
         pre_q <= 2'b00;
         vpr_q <= 2'b00;
      end else begin
         if (wr_ctrl && wstrb_q[0]) begin
            // irq enable can only be written in automatic mode
            if (auto_q) begin
               pll_irq_enable_q <= ctrl_w[pllc_pkg::CTRL_IE];
            end
            // clearing enable is blocked while the vco path is selected
            if (ctrl_w[pllc_pkg::CTRL_ON] || !base_clock_select_q) begin
               pll_enable_q <= ctrl_w[pllc_pkg::CTRL_ON];
            end
            if (!pll_enable_q) begin
               pre_q <= ctrl_w[pllc_pkg::CTRL_PRE +: 2];
               vpr_q <= ctrl_w[pllc_pkg::CTRL_VPR +: 2];
            end
         end
         if (range_zero) begin
            base_clock_select_q <= 1'b0;
         end else if (wr_ctrl && wstrb_q[0]) begin
            // lock is not consulted: software may select while unlocked
            if (!ctrl_w[pllc_pkg::CTRL_BCS] || pll_enable_q) begin
               base_clock_select_q <= ctrl_w[pllc_pkg::CTRL_BCS];
            end
         end
      end
   end

   // bandwidth and break control; manual value written only in manual mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         auto_q <= 1'b0;
         acq_q <= 1'b0;
         break_clear_enable_q <= 1'b0;
      end else begin
         if (wr_go && awaddr_q == pllc_pkg::BW_OFS && wstrb_q[0]) begin
            auto_q <= wdata_q[pllc_pkg::BW_AUTO];
            // in auto mode the manual value is kept for later
            if (!auto_q) begin
               acq_q <= wdata_q[pllc_pkg::BW_ACQ];
            end
         end
         if (wr_go && awaddr_q == pllc_pkg::BRK_OFS && wstrb_q[0]) begin
            break_clear_enable_q <= wdata_q[pllc_pkg::BRK_BREAK_CLEAR_ENABLE];
         end
      end
   end

   // protected programming registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mul_q <= pllc_pkg::MUL_RST;
         vco_range_field_q <= pllc_pkg::VRS_RST;
         ref_divider_field_q <= pllc_pkg::RDS_RST;
      end else if (wr_go && !pll_enable_q) begin
         if (awaddr_q == pllc_pkg::MUL_OFS) begin
            mul_q <= 12'(merge({20'h0_0000, mul_q}, wdata_q, wstrb_q));
         end else if (awaddr_q == pllc_pkg::VRS_OFS && wstrb_q[0]) begin
            vco_range_field_q <= wdata_q[7:0];
         end else if (awaddr_q == pllc_pkg::RDS_OFS && wstrb_q[0]) begin
            ref_divider_field_q <= wdata_q[3:0];
         end
      end
   end

   // lock change flag; a change in the clearing cycle still sets it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lock_d1_q <= 1'b0;
         pll_irq_flag_q <= 1'b0;
      end else begin
         lock_d1_q <= lock_s;
         if (lock_chg && auto_q) begin
            pll_irq_flag_q <= 1'b1;
         end else if (flag_clr || !auto_q) begin
            pll_irq_flag_q <= 1'b0;
         end
      end
   end

   // read mux; lock and flag read zero in manual mode
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_hit = 1'b1;
      if (s_axi_araddr == pllc_pkg::CTRL_OFS) begin
         rd_val[pllc_pkg::CTRL_IE] = pll_irq_enable_q & auto_q;
         rd_val[pllc_pkg::CTRL_IF] = pll_irq_flag_q & auto_q;
         rd_val[pllc_pkg::CTRL_ON] = pll_enable_q;
         rd_val[pllc_pkg::CTRL_BCS] = base_clock_select_q;
         rd_val[pllc_pkg::CTRL_PRE +: 2] = pre_q;
         rd_val[pllc_pkg::CTRL_VPR +: 2] = vpr_q;
      end else if (s_axi_araddr == pllc_pkg::BW_OFS) begin
         rd_val[pllc_pkg::BW_AUTO] = auto_q;
         rd_val[pllc_pkg::BW_LOCK] = lock_s & auto_q;
         rd_val[pllc_pkg::BW_ACQ] = auto_q ? lock_s : acq_q;
      end else if (s_axi_araddr == pllc_pkg::MUL_OFS) begin
         rd_val[11:0] = mul_q;
      end else if (s_axi_araddr == pllc_pkg::VRS_OFS) begin
         rd_val[7:0] = vco_range_field_q;
      end else if (s_axi_araddr == pllc_pkg::RDS_OFS) begin
         rd_val[3:0] = ref_divider_field_q;
      end else if (s_axi_araddr == pllc_pkg::BRK_OFS) begin
         rd_val[pllc_pkg::BRK_BREAK_CLEAR_ENABLE] = break_clear_enable_q;
      end else begin
         rd_hit = 1'b0;
      end
   end

   // read channel, data registered one cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= pllc_pkg::RESP_OKAY;
      end else if (rd_go) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_hit ? pllc_pkg::RESP_OKAY : pllc_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign s_axi_arready = ~s_axi_rvalid;

   // registered controls to the analog loop; wait mode is not an input at all
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pll_irq <= 1'b0;
         pll_run <= 1'b0;
         vco_range <= pllc_pkg::VRS_RST;
         ref_div <= pllc_pkg::RDS_RST;
         feedback_mul <= pllc_pkg::MUL_RST;
         prescale <= 2'b00;
         vco_power <= 2'b00;
         auto_bw <= 1'b0;
         acq_track <= 1'b0;
      end else begin
         pll_irq <= pll_irq_flag_q & pll_irq_enable_q & auto_q;
         pll_run <= pll_enable_q & ~range_zero & ~stop_mode;
         vco_range <= vco_range_field_q;
         ref_div <= 4'(zero_as_one({8'h00, ref_divider_field_q}));
         feedback_mul <= zero_as_one(mul_q);
         prescale <= pre_q;
         vco_power <= vpr_q;
         auto_bw <= auto_q;
         acq_track <= auto_q ? lock_s : acq_q;
      end
   end

   pllc_clk_switch u_switch (
      .aclk(aclk),
      .aresetn(aresetn),
      .osc_lvl(osc_s),
      .vco_lvl(vco_gated),
      .sel_req(base_clock_select_q),
      .base_clock_out(base_clock_out),
      .sel_active(base_vco_active)
   );
endmodule : pllc_top

// >>> bench/pllc_properties.sv
`timescale 1ns/1ps
// port-level checks of bus timing, field protection and irq gating
module pllc_properties (
   input wire logic aclk, // system clock
   input wire logic aresetn, // synchronous reset, active low
   input wire logic s_axi_awvalid, // write address valid
   input wire logic s_axi_awready, // write address ready
   input wire logic s_axi_wvalid, // write data valid
   input wire logic s_axi_wready, // write data ready
   input wire logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic s_axi_arvalid, // read address valid
   input wire logic s_axi_arready, // read address ready
   input wire logic s_axi_rvalid, // read data valid
   input wire logic stop_mode, // stop mode active
   input wire logic pll_irq, // interrupt request
   input wire logic pll_run, // loop enable
   input wire logic auto_bw, // automatic bandwidth
   input wire logic [7:0] vco_range, // range multiplier
   input wire logic [3:0] ref_div, // effective divider
   input wire logic [11:0] feedback_mul // effective multiplier
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // both write halves taken at one edge
   sequence wr_taken_s;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // read address taken
   sequence ar_taken_s;
      s_axi_arvalid && s_axi_arready;
   endsequence
   wr_answer_a: assert property (wr_taken_s |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   rd_answer_a: assert property (ar_taken_s |=> s_axi_rvalid)
      else $error("read data late");
   resp_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not released");
   range_zero_a: assert property (vco_range == 8'h00 && $past(vco_range) == 8'h00 |-> !pll_run)
      else $error("loop runs with zero range");
   stop_off_a: assert property (stop_mode && $past(stop_mode) |-> !pll_run)
      else $error("loop runs in stop");
   manual_quiet_a: assert property (!auto_bw && !$past(auto_bw) |-> !pll_irq)
      else $error("irq in manual mode");
   div_nonzero_a: assert property (ref_div != 4'h0)
      else $error("divider shows zero");
   mul_nonzero_a: assert property (feedback_mul != 12'h000)
      else $error("multiplier shows zero");
   // protected fields never move while the loop runs
   locked_fields_a: assert property (pll_run && $past(pll_run) |-> $stable(vco_range)
      && $stable(ref_div) && $stable(feedback_mul)) else $error("protected field moved");
   irq_cause_a: assert property ($rose(pll_irq) |-> auto_bw)
      else $error("irq without auto mode");
endmodule : pllc_properties

bind pllc_top pllc_properties u_pllc_properties (.*);

// >>> bench/pllc_test.sv
`timescale 1ns/1ps
// register-level tests driven over the bus
module pllc_test;
   logic aclk = 1'b0, aresetn = 1'b0; // clock, reset
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00; // addresses
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata; // data
   logic [3:0] s_axi_wstrb = 4'hF; // all lanes
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, prescale, vco_power, brsp, rrsp;
   logic pll_locked_in = 1'b0, osc_clock = 1'b0, divided_vco_clock = 1'b0;
   logic stop_mode = 1'b0, debug_break = 1'b0;
   logic pll_irq, pll_run, auto_bw, acq_track, base_clock_out, base_vco_active;
   logic [7:0] vco_range;
   logic [3:0] ref_div, cnt = 4'h0;
   logic [11:0] feedback_mul;
   logic [31:0] rdat; // last read data
   int num_errors = 0, checks_done = 0;
   pllc_top u_pllc_top (.*);
   initial forever #25 aclk = ~aclk;
   // slow source clocks, well under a quarter of aclk
   always @(posedge aclk) begin
      cnt <= cnt + 4'h1;
      osc_clock <= cnt[2];
      divided_vco_clock <= cnt[3];
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   // one write; halves released as taken, bready held until answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!(s_axi_bvalid === 1'b1 && !s_axi_awvalid && !s_axi_wvalid) && n < 50);
      brsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   // one read; rready held until rvalid is seen
   task automatic rd(input logic [7:0] a);
      int n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (s_axi_rvalid !== 1'b1 && n < 50);
      rdat = s_axi_rdata;
      rrsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      rd(a);
      chk(rdat, e);
   endtask : rc
   // flip lock and let it cross the synchroniser
   task automatic lk;
      pll_locked_in <= ~pll_locked_in;
      repeat (8) @(posedge aclk);
   endtask : lk
   // bounded wait for the switch to settle on a source
   task automatic wsw(input logic v);
      int n = 0;
      while (base_vco_active !== v && n < 300) begin
         @(posedge aclk);
         n++;
      end
      chk(32'(base_vco_active), 32'(v));
   endtask : wsw
   task automatic results;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results
   // hang guard, far above the expected run
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      results();
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rc(pllc_pkg::VRS_OFS, 32'h0000_0040);
      rc(pllc_pkg::RDS_OFS, 32'h0000_0001);
      rc(pllc_pkg::MUL_OFS, 32'h0000_0040);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_0020);
      $display("reset values done");
      wr(pllc_pkg::VRS_OFS, 32'h0000_0011);
      wr(pllc_pkg::RDS_OFS, 32'h0000_0005);
      wr(pllc_pkg::MUL_OFS, 32'h0000_0123);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_003F);
      rc(pllc_pkg::VRS_OFS, 32'h0000_0040);
      rc(pllc_pkg::RDS_OFS, 32'h0000_0001);
      rc(pllc_pkg::MUL_OFS, 32'h0000_0040);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_0030);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0000);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_0020);
      $display("protection done");
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0000);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0010);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_0000);
      wr(pllc_pkg::VRS_OFS, 32'h0000_0000);
      wr(pllc_pkg::RDS_OFS, 32'h0000_0000);
      wr(pllc_pkg::MUL_OFS, 32'h0000_0000);
      repeat (2) @(posedge aclk);
      chk(32'(ref_div), 32'h0000_0001);
      chk(32'(feedback_mul), 32'h0000_0001);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0020);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0030);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_0020);
      chk(32'(pll_run), 32'h0000_0000);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0000);
      wr(pllc_pkg::VRS_OFS, 32'h0000_0040);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0020);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0030);
      wsw(1'b1);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0020);
      wsw(1'b0);
      $display("select done");
      lk();
      rc(pllc_pkg::CTRL_OFS, 32'h0000_0020);
      wr(pllc_pkg::BW_OFS, 32'h0000_0080);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_00A0);
      lk();
      chk(32'(pll_irq), 32'h0000_0001);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_00E0);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_00A0);
      debug_break <= 1'b1;
      lk();
      rc(pllc_pkg::CTRL_OFS, 32'h0000_00E0);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_00E0);
      wr(pllc_pkg::BRK_OFS, 32'h0000_0080);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_00E0);
      debug_break <= 1'b0;
      rc(pllc_pkg::CTRL_OFS, 32'h0000_00A0);
      wr(pllc_pkg::CTRL_OFS, 32'h0000_0020);
      lk();
      chk(32'(pll_irq), 32'h0000_0000);
      rc(pllc_pkg::CTRL_OFS, 32'h0000_0060);
      rc(pllc_pkg::BW_OFS, 32'h0000_0080);
      $display("interrupt done");
      rd(8'h18);
      chk(32'(rrsp), 32'(pllc_pkg::RESP_SLVERR));
      chk(rdat, 32'h0000_0000);
      wr(8'h18, 32'h0000_00FF);
      chk(32'(brsp), 32'(pllc_pkg::RESP_SLVERR));
      stop_mode <= 1'b1;
      repeat (3) @(posedge aclk);
      chk(32'(pll_run), 32'h0000_0000);
      stop_mode <= 1'b0;
      repeat (3) @(posedge aclk);
      chk(32'(pll_run), 32'h0000_0001);
      $display("stop and unmapped done");
      results();
   end
endmodule : pllc_test
